// ==== design/cawo_top.sv ====
/*
  Waveform output channel of a counter array: shared main counter with
  selectable prescale, frequency output, edge and center aligned
  modulation, output polarity and an AXI4-Lite register slave.
  Assumes one clock, an AXI4-Lite master keeping valid and payload stable
  until ready, and software that follows the buffered update scheme.
*/
// Contract
// - Frequency mode toggles after high-byte counter clocks
// - High byte zero means 256 clocks
// - Low byte match toggles, adds high byte
// - Frequency mode flag on full 16-bit match
// - Per-channel bit selects edge or center alignment
// - Shared 8 to 11-bit resolution setting
// - Edge mode: match high, overflow low
// - Match edge on low N bits equal
// - Overflow edge when low N bits roll
// - Polarity bit inverts output at pin
// - Unused upper bits ignored for edges
// - Compare disabled gives 0% duty
// - Edge duty is (2^N minus compare)/2^N
// - Center mode: up high, down low
// - Counter bit N picks edge; 17th bit
// - Down edge: bit N one, complement matches
// - Up edge: bit N zero, compare equals minus one
// - Center point output follows bit N
// - Center all zeros 100%, all ones 0%
// - Center duty is (2^N minus compare minus half)/2^N
// - Reload compare at overflow or up edge
// - Low byte write clears, high sets compare enable
`timescale 1ns/100ps
module cawo_top (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire cawo_pkg::cawo_axi_req_t i_axi,
  output cawo_pkg::cawo_axi_rsp_t o_axi,
  output logic o_channel_output_pin,
  output logic o_channel_event_flag
);

  // ----------------------------------------------------------------------
  // State and decode signals
  // ----------------------------------------------------------------------
  cawo_pkg::cawo_state_t s_q;
  cawo_pkg::cawo_state_t s_d;
  logic [7:0] div_limit;
  logic tick;
  logic [4:0] res_n;
  logic [16:0] mask;
  logic [16:0] nv;
  logic [16:0] nl;
  logic [16:0] cp;
  logic sel_bit;
  logic mode_pwm;
  logic mode_freq;
  logic narrow;
  logic ea_match;
  logic ea_ovf;
  logic ca_up;
  logic ca_down;
  logic ca_full;
  logic ca_none;
  logic fo_match;
  logic [7:0] fo_sum;
  logic reload_evt;
  logic ev_set;
  logic wave_next;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic [cawo_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic ar_take;

  // Counter clock from prescaler
  assign div_limit = 8'((9'h001 << s_q.clk_sel) - 9'h001);
  assign tick = s_q.run && (s_q.div == div_limit);

  // Resolution shared by all narrow channels, or 16 bits
  assign res_n = s_q.sixteen ? cawo_pkg::RES_WIDE
                             : cawo_pkg::RES_BASE + {3'h0, s_q.cyc_len};
  assign mask = 17'((18'h00001 << res_n) - 18'h00001);
  assign nv = s_q.count + 17'h00001;
  assign nl = nv & mask;
  assign cp = {1'b0, s_q.cmp} & mask;
  assign sel_bit = nv[res_n];

  // Mode decode
  assign mode_pwm = s_q.wave_en && !s_q.toggle_en;
  assign mode_freq = s_q.cmp_en && s_q.toggle_en && s_q.wave_en;
  assign narrow = !s_q.sixteen && (s_q.cyc_len != 2'h0);

  // Edges on the next counter value; down edge on the current one, giving the half count
  assign ea_match = s_q.cmp_en && (nl == cp);
  assign ea_ovf = (nl == 17'h00000);
  assign ca_down = s_q.count[res_n] && ((~cp & mask) == (s_q.count & mask));
  assign ca_up = !sel_bit && (cp == (17'(nl - 17'h00001) & mask));
  assign ca_full = (cp == 17'h00000);
  assign ca_none = (cp == mask);
  assign fo_match = (nv[7:0] == s_q.cmp[7:0]);
  assign fo_sum = s_q.cmp[7:0] + s_q.cmp[15:8];
  assign reload_evt = tick && mode_pwm && (s_q.center ? ca_up : ea_ovf);

  // Channel event flag sources
  always_comb begin
    ev_set = 1'b0;
    if (tick && s_q.match_en) begin
      if (mode_freq) begin
        ev_set = (nv[15:0] == s_q.cmp);
      end else if (mode_pwm && s_q.cmp_en) begin
        ev_set = s_q.center ? ca_up : ea_match;
      end
    end
  end

  // Waveform level for the next cycle
  always_comb begin
    wave_next = s_q.wave;
    if (mode_pwm) begin
      if (!s_q.cmp_en) begin
        wave_next = 1'b0;
      end else if (s_q.center) begin
        // Output centered on low bits zero, level set by bit N
        if (ca_full) begin
          wave_next = 1'b1;
        end else if (ca_none) begin
          wave_next = 1'b0;
        end else if (tick && ca_up) begin
          wave_next = 1'b1;
        end else if (tick && ca_down) begin
          wave_next = 1'b0;
        end
      end else begin
        // Match wins over overflow so compare zero gives full duty
        if (tick && ea_match) begin
          wave_next = 1'b1;
        end else if (tick && ea_ovf) begin
          wave_next = 1'b0;
        end
      end
    end else if (mode_freq && tick && fo_match) begin
      wave_next = !s_q.wave;
    end
  end

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  assign o_axi.awready = !s_q.aw_have && !s_q.bvalid;
  assign o_axi.wready = !s_q.w_have && !s_q.bvalid;
  assign o_axi.arready = !s_q.rvalid;
  assign o_axi.bvalid = s_q.bvalid;
  assign o_axi.bresp = s_q.bresp;
  assign o_axi.rvalid = s_q.rvalid;
  assign o_axi.rdata = s_q.rdata;
  assign o_axi.rresp = s_q.rresp;
  assign aw_take = i_axi.awvalid && o_axi.awready;
  assign w_take = i_axi.wvalid && o_axi.wready;
  assign wr_go = (s_q.aw_have || aw_take) && (s_q.w_have || w_take);
  assign wr_addr = s_q.aw_have ? s_q.aw_addr : i_axi.awaddr;
  assign wr_data = s_q.w_have ? s_q.w_data : i_axi.wdata;
  assign wr_strb = s_q.w_have ? s_q.w_strb : i_axi.wstrb;
  assign ar_take = i_axi.arvalid && o_axi.arready;
  assign o_channel_output_pin = s_q.pin;
  assign o_channel_event_flag = s_q.event_flag;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [31:0] rd_val;
    logic rd_ok;
    logic wr_ok;
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    s_d = s_q;

    // Prescaler and main counter
    if (s_q.run) begin
      s_d.div = tick ? 8'h00 : s_q.div + 8'h01;
    end
    if (tick) begin
      s_d.count = nv;
    end

    // Hardware compare updates
    if (mode_freq && tick && fo_match) begin
      s_d.cmp[7:0] = fo_sum;
    end
    if (reload_evt) begin
      if (narrow) begin
        s_d.cmp = s_q.reload;
      end else if (!s_q.sixteen) begin
        s_d.cmp[7:0] = s_q.cmp[15:8];
      end
    end

    // Output level and pin polarity
    s_d.wave = wave_next;
    s_d.pin = wave_next ^ s_q.invert;

    // Write channel capture
    if (aw_take) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = i_axi.awaddr;
    end
    if (w_take) begin
      s_d.w_have = 1'b1;
      s_d.w_data = i_axi.wdata;
      s_d.w_strb = i_axi.wstrb;
    end
    if (s_q.bvalid && i_axi.bready) begin
      s_d.bvalid = 1'b0;
    end

    // Register writes; software wins over hardware compare updates
    if (wr_go) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      if (wr_strb[0]) begin
        case (wr_addr)
          cawo_pkg::OFF_COUNTER_MODE: begin
            s_d.run = wr_data[cawo_pkg::CM_RUN_BIT];
            s_d.clk_sel = wr_data[cawo_pkg::CM_CLK_SEL_LSB +: 3];
            s_d.div = 8'h00;
          end
          cawo_pkg::OFF_COUNTER: begin
            s_d.count[7:0] = wr_data[7:0];
          end
          cawo_pkg::OFF_MOD_CONFIG: begin
            s_d.cyc_len = wr_data[cawo_pkg::MC_CYCLE_LEN_LSB +: 2];
            s_d.reload_sel = wr_data[cawo_pkg::MC_RELOAD_SEL_BIT];
          end
          cawo_pkg::OFF_CHANNEL_MODE: begin
            s_d.wave_en = wr_data[cawo_pkg::CH_WAVE_BIT];
            s_d.toggle_en = wr_data[cawo_pkg::CH_TOGGLE_BIT];
            s_d.match_en = wr_data[cawo_pkg::CH_MATCH_BIT];
            s_d.cmp_en = wr_data[cawo_pkg::CH_CMP_EN_BIT];
            s_d.sixteen = wr_data[cawo_pkg::CH_SIXTEEN_BIT];
          end
          cawo_pkg::OFF_COMPARE_LOW: begin
            if (s_q.reload_sel) begin
              s_d.reload[7:0] = wr_data[7:0];
            end else begin
              s_d.cmp[7:0] = wr_data[7:0];
            end
            s_d.cmp_en = 1'b0;
          end
          cawo_pkg::OFF_COMPARE_HIGH: begin
            if (s_q.reload_sel) begin
              s_d.reload[15:8] = wr_data[7:0];
            end else begin
              s_d.cmp[15:8] = wr_data[7:0];
            end
            s_d.cmp_en = 1'b1;
          end
          cawo_pkg::OFF_CENTER_SELECT: begin
            s_d.center = wr_data[0];
          end
          cawo_pkg::OFF_POLARITY: begin
            s_d.invert = wr_data[0];
          end
          cawo_pkg::OFF_STATUS: begin
            if (wr_data[cawo_pkg::ST_EVENT_BIT]) begin
              s_d.event_flag = 1'b0;
            end
          end
          default: begin
            wr_ok = 1'b0;
          end
        endcase
      end else if (wr_addr != cawo_pkg::OFF_COUNTER) begin
        wr_ok = (wr_addr <= cawo_pkg::OFF_STATUS) && (wr_addr[1:0] == 2'h0);
      end
      if (wr_strb[1] && (wr_addr == cawo_pkg::OFF_COUNTER)) begin
        s_d.count[15:8] = wr_data[15:8];
      end
      s_d.bresp = wr_ok ? cawo_pkg::RESP_OKAY : cawo_pkg::RESP_SLVERR;
    end

    // Flag set wins over a clear in the same cycle
    if (ev_set) begin
      s_d.event_flag = 1'b1;
    end

    // Read mux
    case (i_axi.araddr)
      cawo_pkg::OFF_COUNTER_MODE: begin
        rd_val[cawo_pkg::CM_RUN_BIT] = s_q.run;
        rd_val[cawo_pkg::CM_CLK_SEL_LSB +: 3] = s_q.clk_sel;
      end
      cawo_pkg::OFF_COUNTER: rd_val[15:0] = s_q.count[15:0];
      cawo_pkg::OFF_MOD_CONFIG: begin
        rd_val[cawo_pkg::MC_CYCLE_LEN_LSB +: 2] = s_q.cyc_len;
        rd_val[cawo_pkg::MC_RELOAD_SEL_BIT] = s_q.reload_sel;
      end
      cawo_pkg::OFF_CHANNEL_MODE: begin
        rd_val[cawo_pkg::CH_WAVE_BIT] = s_q.wave_en;
        rd_val[cawo_pkg::CH_TOGGLE_BIT] = s_q.toggle_en;
        rd_val[cawo_pkg::CH_MATCH_BIT] = s_q.match_en;
        rd_val[cawo_pkg::CH_CMP_EN_BIT] = s_q.cmp_en;
        rd_val[cawo_pkg::CH_SIXTEEN_BIT] = s_q.sixteen;
      end
      cawo_pkg::OFF_COMPARE_LOW: begin
        rd_val[7:0] = s_q.reload_sel ? s_q.reload[7:0] : s_q.cmp[7:0];
      end
      cawo_pkg::OFF_COMPARE_HIGH: begin
        rd_val[7:0] = s_q.reload_sel ? s_q.reload[15:8] : s_q.cmp[15:8];
      end
      cawo_pkg::OFF_CENTER_SELECT: rd_val[0] = s_q.center;
      cawo_pkg::OFF_POLARITY: rd_val[0] = s_q.invert;
      cawo_pkg::OFF_STATUS: rd_val[cawo_pkg::ST_EVENT_BIT] = s_q.event_flag;
      default: rd_ok = 1'b0;
    endcase
    if (s_q.rvalid && i_axi.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_val;
      s_d.rresp = rd_ok ? cawo_pkg::RESP_OKAY : cawo_pkg::RESP_SLVERR;
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
      s_q.clk_sel <= cawo_pkg::RST_CLK_SEL;
      s_q.cyc_len <= cawo_pkg::RST_CYCLE_LEN;
      s_q.cmp <= cawo_pkg::RST_COMPARE;
      s_q.reload <= cawo_pkg::RST_RELOAD;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  a_freq_toggle_out: assert property (
    tick && mode_freq && fo_match |=> s_q.wave != $past(s_q.wave))
    else $error("frequency output did not toggle on match");
  a_freq_next_point: assert property (
    tick && mode_freq && fo_match && !wr_go |=> s_q.cmp[7:0] == $past(fo_sum))
    else $error("frequency match point not advanced by high byte");
  a_freq_full_flag: assert property (
    tick && mode_freq && s_q.match_en && nv[15:0] == s_q.cmp
    |=> s_q.event_flag)
    else $error("flag not set on full compare match");
  a_edge_match_high: assert property (
    tick && mode_pwm && !s_q.center && ea_match
    |=> s_q.wave && (o_channel_output_pin != $past(s_q.invert)))
    else $error("match edge did not drive output high");
  a_edge_ovf_low: assert property (
    tick && mode_pwm && !s_q.center && ea_ovf && !ea_match |=> !s_q.wave)
    else $error("overflow edge did not drive output low");
  a_cmp_off_zero: assert property (
    mode_pwm && !s_q.cmp_en |=> !s_q.wave)
    else $error("disabled compare did not give zero duty");
  a_center_up_high: assert property (
    tick && mode_pwm && s_q.center && s_q.cmp_en && ca_up && !ca_none |=> s_q.wave)
    else $error("up edge did not drive output high");
  a_center_down_low: assert property (
    tick && mode_pwm && s_q.center && s_q.cmp_en && ca_down && !ca_full |=> !s_q.wave)
    else $error("down edge did not drive output low");
  a_center_full_duty: assert property (
    mode_pwm && s_q.center && s_q.cmp_en && ca_full |=> s_q.wave)
    else $error("center compare zero not at full duty");
  a_pin_polarity: assert property (
    1'b1 |=> o_channel_output_pin == (s_q.wave ^ $past(s_q.invert)))
    else $error("pin level does not follow polarity");
  a_count_bit17: assert property (
    tick && s_q.count[15:0] == 16'hffff |=> s_q.count[16] != $past(s_q.count[16]))
    else $error("internal seventeenth counter bit did not toggle");
  a_narrow_reload: assert property (
    reload_evt && narrow && !wr_go |=> s_q.cmp == $past(s_q.reload))
    else $error("compare not reloaded at reload edge");
  a_low_write_off: assert property (
    wr_go && wr_strb[0] && wr_addr == cawo_pkg::OFF_COMPARE_LOW |=> !s_q.cmp_en)
    else $error("low byte write did not clear compare enable");
  a_high_write_on: assert property (
    wr_go && wr_strb[0] && wr_addr == cawo_pkg::OFF_COMPARE_HIGH |=> s_q.cmp_en)
    else $error("high byte write did not set compare enable");

  c_freq_toggle: cover property (tick && mode_freq && fo_match);
  c_edge_match: cover property (tick && mode_pwm && !s_q.center && ea_match);
  c_center_up: cover property (tick && mode_pwm && s_q.center && ca_up);
  c_reload: cover property (reload_evt && narrow);

endmodule

// ==== shared/cawo_pkg.sv ====
/*
  Constants, register map and carrier types for the counter array
  waveform output channel.
  Assumes a 32-bit AXI4-Lite master and byte addresses of aligned words.
*/
package cawo_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFF_COUNTER_MODE = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_COUNTER = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_MOD_CONFIG = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_CHANNEL_MODE = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_COMPARE_LOW = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_COMPARE_HIGH = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_CENTER_SELECT = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_POLARITY = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h20;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CM_RUN_BIT = 0;
  localparam int CM_CLK_SEL_LSB = 1;
  localparam int MC_CYCLE_LEN_LSB = 0;
  localparam int MC_RELOAD_SEL_BIT = 5;
  localparam int CH_WAVE_BIT = 1;
  localparam int CH_TOGGLE_BIT = 2;
  localparam int CH_MATCH_BIT = 3;
  localparam int CH_CMP_EN_BIT = 6;
  localparam int CH_SIXTEEN_BIT = 7;
  localparam int ST_EVENT_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_COMPARE = 16'h0000;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [2:0] RST_CLK_SEL = 3'h0;
  localparam logic [1:0] RST_CYCLE_LEN = 2'h0;
  localparam logic [4:0] RES_BASE = 5'h08;
  localparam logic [4:0] RES_WIDE = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } cawo_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cawo_axi_rsp_t;

  typedef struct packed {
    logic run;
    logic [2:0] clk_sel;
    logic [7:0] div;
    logic [16:0] count;
    logic [1:0] cyc_len;
    logic reload_sel;
    logic sixteen;
    logic cmp_en;
    logic match_en;
    logic toggle_en;
    logic wave_en;
    logic [15:0] cmp;
    logic [15:0] reload;
    logic center;
    logic invert;
    logic event_flag;
    logic wave;
    logic pin;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } cawo_state_t;

endpackage

// ==== tb/cawo_load.sv ====
/*
  Load model on the channel output pin: counts high cycles since a clear
  and measures the cycles between the last two pin transitions.
  Assumes the pin is sampled on the system clock.
*/
`timescale 1ns/100ps
module cawo_load (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_pin,
  input wire logic i_clear,
  output logic [31:0] o_high,
  output logic [31:0] o_gap
);
  logic last_q;
  logic [31:0] run_q;

  // High time and transition spacing
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      last_q <= 1'b0;
      run_q <= 32'h0;
      o_high <= 32'h0;
      o_gap <= 32'h0;
    end else begin
      last_q <= i_pin;
      o_high <= i_clear ? 32'h0 : o_high + {31'h0, i_pin};
      if (i_pin !== last_q) begin
        o_gap <= run_q + 32'h1;
        run_q <= 32'h0;
      end else begin
        run_q <= run_q + 32'h1;
      end
    end
  end
endmodule

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the waveform output channel: AXI4-Lite
  register access, modulation duty, disable, flag and frequency output.
  Assumes the load model and the design package are compiled first.
*/
`timescale 1ns/100ps
module testbench;
  logic i_clock;
  logic i_reset_n;
  cawo_pkg::cawo_axi_req_t req;
  cawo_pkg::cawo_axi_rsp_t rsp;
  logic pin, flag, clr;
  logic [31:0] high, gap, rd;
  logic [1:0] rs;
  int fails, checked, seed, cyc, per;
  bit cen, inv;
  logic [15:0] val;
  logic [7:0] hv;
  int cc[4] = '{0, 0, 0, 1};
  bit cn[4] = '{1, 1, 0, 1};
  bit iv[4] = '{0, 0, 1, 1};
  logic [15:0] vv[4] = '{16'h0000, 16'h00ff, 16'h0040, 16'hfe01};

  cawo_top i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_axi(req), .o_axi(rsp),
    .o_channel_output_pin(pin), .o_channel_event_flag(flag));
  cawo_load i_load (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(pin), .i_clear(clr),
    .o_high(high), .o_gap(gap));

  // Clock
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic end_of_test;
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 1000) begin
      fails++;
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------
  // AXI4-Lite master
  // ----------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    logic ad, dd, at, wt, ok;
    @(posedge i_clock);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    n = 0;
    while (!(ad && dd) && n < 1000) begin
      @(negedge i_clock);
      at = !ad && rsp.awready;
      wt = !dd && rsp.wready;
      @(posedge i_clock);
      if (at) req.awvalid <= 1'b0;
      if (wt) req.wvalid <= 1'b0;
      ad = ad | at;
      dd = dd | wt;
      n++;
    end
    tmo(n);
    n = 0;
    ok = 1'b0;
    while (!ok && n < 1000) begin
      @(negedge i_clock);
      ok = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge i_clock);
      n++;
    end
    req.bready <= 1'b0;
    tmo(n);
  endtask

  task automatic rdr(input logic [5:0] a);
    int n;
    logic ok;
    @(posedge i_clock);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 1000) begin
      @(negedge i_clock);
      ok = rsp.arready;
      @(posedge i_clock);
      n++;
    end
    req.arvalid <= 1'b0;
    tmo(n);
    n = 0;
    ok = 1'b0;
    while (!ok && n < 1000) begin
      @(negedge i_clock);
      ok = rsp.rvalid;
      rd = rsp.rdata;
      rs = rsp.rresp;
      @(posedge i_clock);
      n++;
    end
    req.rready <= 1'b0;
    tmo(n);
  endtask

  // ----------------------------------------------------------------
  // Channel setup, measurement and expectation
  // ----------------------------------------------------------------
  task automatic setup(input int c, input bit ce, input bit iv_b, input logic [15:0] v);
    wr(cawo_pkg::OFF_MOD_CONFIG, (c == 0) ? 32'h0 : (32'h20 | 32'(c)));
    wr(cawo_pkg::OFF_CENTER_SELECT, {31'h0, ce});
    wr(cawo_pkg::OFF_POLARITY, {31'h0, iv_b});
    wr(cawo_pkg::OFF_CHANNEL_MODE, 32'h4a);
    wr(cawo_pkg::OFF_COMPARE_LOW, {24'h0, v[7:0]});
    rdr(cawo_pkg::OFF_CHANNEL_MODE);
    chk("mode after low byte", 32'h0a, rd);
    wr(cawo_pkg::OFF_COMPARE_HIGH, {24'h0, (c == 0) ? v[7:0] : v[15:8]});
    rdr(cawo_pkg::OFF_CHANNEL_MODE);
    chk("mode after high byte", 32'h4a, rd);
  endtask

  // Settle two periods, then count high cycles over one period
  task automatic meas(input int p);
    repeat (2 * p) @(posedge i_clock);
    clr <= 1'b1;
    @(posedge i_clock);
    clr <= 1'b0;
    repeat (p) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  function automatic logic [31:0] exp_high(input int c, input bit ce, input bit iv_b,
                                           input logic [15:0] v);
    int m, k, p, h;
    m = 1 << (8 + c);
    k = int'(v) & (m - 1);
    p = ce ? 2 * m : m;
    if (!ce) h = m - k;
    else if (k == 0) h = p;
    else if (k == m - 1) h = 0;
    else h = p - 2 * k - 1;
    if (iv_b) h = p - h;
    return 32'(h);
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 19;
    fails = 0;
    checked = 0;
    req = '0;
    clr = 1'b0;
    i_reset_n = 1'b0;
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rdr(cawo_pkg::OFF_COMPARE_LOW);
    chk("reset compare", 32'h0, rd);
    rdr(6'h24);
    chk("unmapped rdata", 32'h0, rd);
    chk("unmapped rresp", {30'h0, cawo_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(6'h3c, 32'hffffffff);
    chk("unmapped bresp", {30'h0, cawo_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(cawo_pkg::OFF_COUNTER_MODE, 32'h1);
    // Modulation corners, then random settings
    for (int i = 0; i < 10; i++) begin
      if (i < 4) begin
        cyc = cc[i];
        cen = cn[i];
        inv = iv[i];
        val = vv[i];
      end else begin
        cyc = $unsigned($random(seed)) % 3;
        cen = 1'($random(seed));
        inv = 1'($random(seed));
        val = 16'($random(seed));
      end
      setup(cyc, cen, inv, val);
      per = (cen ? 2 : 1) << (8 + cyc);
      meas(per);
      chk("high count", exp_high(cyc, cen, inv, val), high);
    end
    // Flag, compare disable and flag clear
    wr(cawo_pkg::OFF_CHANNEL_MODE, 32'h02);
    wr(cawo_pkg::OFF_STATUS, 32'h1);
    rdr(cawo_pkg::OFF_STATUS);
    chk("flag before match", 32'h0, rd);
    setup(0, 1'b0, 1'b0, 16'h0080);
    meas(256);
    chk("event flag", 32'h1, {31'h0, flag});
    wr(cawo_pkg::OFF_CHANNEL_MODE, 32'h0a);
    meas(256);
    chk("disabled high", 32'h0, high);
    wr(cawo_pkg::OFF_STATUS, 32'h1);
    rdr(cawo_pkg::OFF_STATUS);
    chk("flag cleared", 32'h0, rd);
    // Frequency output, last case with a halved counter clock
    for (int k = 0; k < 3; k++) begin
      hv = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : 8'(($unsigned($random(seed)) % 200) + 2);
      wr(cawo_pkg::OFF_COUNTER_MODE, (k == 2) ? 32'h3 : 32'h1);
      wr(cawo_pkg::OFF_CHANNEL_MODE, 32'h46);
      wr(cawo_pkg::OFF_COMPARE_LOW, 32'h0);
      wr(cawo_pkg::OFF_COMPARE_HIGH, {24'h0, hv});
      per = ((hv == 8'h00) ? 256 : int'(hv)) * ((k == 2) ? 2 : 1);
      repeat (600 + 3 * per) @(posedge i_clock);
      @(negedge i_clock);
      chk("half period", 32'(per), gap);
    end
    end_of_test();
  end
endmodule
